// ### design/epic_pkg.sv
// Package for the external pin interrupt control block.
// Assumes a 32-bit APB register bus and one 40 MHz clock.
package epic_pkg;
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] edge_addr = 12'h004;
    localparam logic [11:0] pend_addr = 12'h008;
    localparam logic [11:0] periph_a_addr = 12'h00c;
    localparam logic [11:0] periph_b_addr = 12'h010;
    localparam int flag_one_bit = 0;
    localparam int flag_two_bit = 1;
    localparam int en_one_bit = 3;
    localparam int en_two_bit = 4;
    localparam int prio_one_bit = 6;
    localparam int prio_two_bit = 7;
    localparam int edge_one_bit = 0;
    localparam int edge_two_bit = 1;
    localparam logic [7:0] ctrl_rst = 8'hc0;
    localparam logic [7:0] ctrl_wmask = 8'hdb;
    localparam logic [1:0] edge_rst = 2'h3;
    localparam logic [7:0] periph_rst = 8'h00;
endpackage : epic_pkg

// ### design/epic_top.sv
// External pin interrupt control and status registers behind an APB slave.
// Assumes pins synchronous to pclk and an APB master that holds each request.
// Function
// - Each source latches its flag (bit 1 source two, bit 0 source one) on its event until software writes zero.
// - Enable bits 4 and 3 let source two and source one raise an interrupt when set.
// - A flag sets on its event regardless of its enable bit.
// - Peripheral flags live in two separate registers apart from the pin register.
// - Each source detects the rising edge when its edge select is one, else the falling edge.
`timescale 1ns/1ps
`default_nettype none
module epic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_pin_source_one,
    input wire logic ext_pin_source_two,
    input wire logic [7:0] periph_events_a,
    input wire logic [7:0] periph_events_b,
    output logic src_one_req,
    output logic src_two_req,
    output logic src_one_high,
    output logic src_two_high
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] edge_sel;
        logic [1:0] pin_prev;
        logic [7:0] periph_a;
        logic [7:0] periph_b;
        logic [31:0] rdata;
        logic err;
        logic one_req;
        logic two_req;
        logic one_high;
        logic two_high;
    } epic_state_t;

    epic_state_t s_q, s_d;

    // Returns one when the pin moved in the direction chosen by rise.
    function automatic logic epic_edge(input logic prev, input logic now, input logic rise);
        epic_edge = rise ? (!prev && now) : (prev && !now);
    endfunction : epic_edge

    logic wr_acc;
    logic rd_acc;
    logic ev_one;
    logic ev_two;
    logic mapped;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    logic ctrl_wr;
    assign ctrl_wr = wr_acc && (paddr == epic_pkg::ctrl_addr);
    assign mapped = (paddr == epic_pkg::ctrl_addr) || (paddr == epic_pkg::edge_addr)
        || (paddr == epic_pkg::pend_addr) || (paddr == epic_pkg::periph_a_addr)
        || (paddr == epic_pkg::periph_b_addr);
    assign ev_one = epic_edge(s_q.pin_prev[0], ext_pin_source_one,
        s_q.edge_sel[epic_pkg::edge_one_bit]);
    assign ev_two = epic_edge(s_q.pin_prev[1], ext_pin_source_two,
        s_q.edge_sel[epic_pkg::edge_two_bit]);

    always_comb begin
        s_d = s_q;
        s_d.pin_prev = {ext_pin_source_two, ext_pin_source_one};
        s_d.err = 1'b0;
        if (wr_acc && mapped) begin
            case (paddr)
                epic_pkg::ctrl_addr: begin
                    // Reserved bits stay zero through the write mask.
                    s_d.ctrl = pwdata[7:0] & epic_pkg::ctrl_wmask;
                end
                epic_pkg::edge_addr: begin
                    s_d.edge_sel = pwdata[1:0];
                end
                epic_pkg::periph_a_addr: begin
                    s_d.periph_a = s_q.periph_a & pwdata[7:0];
                end
                epic_pkg::periph_b_addr: begin
                    s_d.periph_b = s_q.periph_b & pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a write of zero in the same cycle, so no event is lost.
        if (ev_one) begin
            s_d.ctrl[epic_pkg::flag_one_bit] = 1'b1;
        end
        if (ev_two) begin
            s_d.ctrl[epic_pkg::flag_two_bit] = 1'b1;
        end
        s_d.periph_a = s_d.periph_a | periph_events_a;
        s_d.periph_b = s_d.periph_b | periph_events_b;
        if (rd_acc) begin
            case (paddr)
                epic_pkg::ctrl_addr: s_d.rdata = {24'h000000, s_q.ctrl};
                epic_pkg::edge_addr: s_d.rdata = {30'h00000000, s_q.edge_sel};
                epic_pkg::pend_addr: s_d.rdata = {28'h0000000, s_q.two_high, s_q.one_high,
                    s_q.two_req, s_q.one_req};
                epic_pkg::periph_a_addr: s_d.rdata = {24'h000000, s_q.periph_a};
                epic_pkg::periph_b_addr: s_d.rdata = {24'h000000, s_q.periph_b};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        s_d.err = psel && !penable && !mapped;
        // Requests follow the stored flag and enable one cycle later.
        s_d.one_req = s_q.ctrl[epic_pkg::flag_one_bit] && s_q.ctrl[epic_pkg::en_one_bit];
        s_d.two_req = s_q.ctrl[epic_pkg::flag_two_bit] && s_q.ctrl[epic_pkg::en_two_bit];
        s_d.one_high = s_q.ctrl[epic_pkg::prio_one_bit];
        s_d.two_high = s_q.ctrl[epic_pkg::prio_two_bit];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{ctrl: epic_pkg::ctrl_rst, edge_sel: epic_pkg::edge_rst, pin_prev: 2'h0,
                periph_a: epic_pkg::periph_rst, periph_b: epic_pkg::periph_rst,
                rdata: 32'h00000000, err: 1'b0, one_req: 1'b0, two_req: 1'b0,
                one_high: 1'b1, two_high: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // The data phase of a read returns the current register word, decoded combinationally from paddr.
    logic [31:0] rd_word;
    always_comb begin
        case (paddr)
            epic_pkg::ctrl_addr: rd_word = {24'h000000, s_q.ctrl};
            epic_pkg::edge_addr: rd_word = {30'h00000000, s_q.edge_sel};
            epic_pkg::pend_addr: rd_word = {28'h0000000, s_q.two_high, s_q.one_high,
                s_q.two_req, s_q.one_req};
            epic_pkg::periph_a_addr: rd_word = {24'h000000, s_q.periph_a};
            epic_pkg::periph_b_addr: rd_word = {24'h000000, s_q.periph_b};
            default: rd_word = 32'h00000000;
        endcase
    end

    assign prdata = rd_word;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign src_one_req = s_q.one_req;
    assign src_two_req = s_q.two_req;
    assign src_one_high = s_q.one_high;
    assign src_two_high = s_q.two_high;

    // Pin histories over two cycles; the edge select counts in the cycle the event is judged.
    sequence epic_rise_one;
        !ext_pin_source_one ##1 (ext_pin_source_one && s_q.edge_sel[epic_pkg::edge_one_bit]);
    endsequence

    sequence epic_fall_one;
        ext_pin_source_one ##1 (!ext_pin_source_one && !s_q.edge_sel[epic_pkg::edge_one_bit]);
    endsequence

    sequence epic_rise_two;
        !ext_pin_source_two ##1 (ext_pin_source_two && s_q.edge_sel[epic_pkg::edge_two_bit]);
    endsequence

    sequence epic_fall_two;
        ext_pin_source_two ##1 (!ext_pin_source_two && !s_q.edge_sel[epic_pkg::edge_two_bit]);
    endsequence

    sequence epic_still_one;
        (ext_pin_source_one ##1 ext_pin_source_one) or (!ext_pin_source_one ##1 !ext_pin_source_one);
    endsequence

    sequence epic_still_two;
        (ext_pin_source_two ##1 ext_pin_source_two) or (!ext_pin_source_two ##1 !ext_pin_source_two);
    endsequence

    a_flag_one_set: assert property (@(posedge pclk) disable iff (!presetn)
        ev_one |=> s_q.ctrl[epic_pkg::flag_one_bit]) else $error("flag one not set");

    a_flag_two_set: assert property (@(posedge pclk) disable iff (!presetn)
        ev_two |=> s_q.ctrl[epic_pkg::flag_two_bit]) else $error("flag two not set");

    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[epic_pkg::flag_one_bit] && !ctrl_wr) |=> s_q.ctrl[epic_pkg::flag_one_bit])
        else $error("flag one dropped");

    a_flag_two_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[epic_pkg::flag_two_bit] && !ctrl_wr) |=> s_q.ctrl[epic_pkg::flag_two_bit])
        else $error("flag two dropped");

    a_flag_one_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && !pwdata[epic_pkg::flag_one_bit] && !ev_one) |=> !s_q.ctrl[epic_pkg::flag_one_bit])
        else $error("flag one not cleared");

    a_flag_two_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && !pwdata[epic_pkg::flag_two_bit] && !ev_two) |=> !s_q.ctrl[epic_pkg::flag_two_bit])
        else $error("flag two not cleared");

    // An event in the cycle of a clearing write must survive it.
    a_set_wins_one: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && ev_one) |=> s_q.ctrl[epic_pkg::flag_one_bit])
        else $error("write beat event one");

    a_set_wins_two: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && ev_two) |=> s_q.ctrl[epic_pkg::flag_two_bit])
        else $error("write beat event two");

    a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_wr && !ev_one && !ev_two) |=> $stable(s_q.ctrl))
        else $error("ctrl changed alone");

    a_req_gated: assert property (@(posedge pclk) disable iff (!presetn)
        src_one_req |-> $past(s_q.ctrl[epic_pkg::en_one_bit])) else $error("req without en");

    a_req_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[epic_pkg::flag_two_bit] && s_q.ctrl[epic_pkg::en_two_bit]) |=> src_two_req)
        else $error("req two missing");

    a_req_one_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[epic_pkg::flag_one_bit] && s_q.ctrl[epic_pkg::en_one_bit]) |=> src_one_req)
        else $error("req one missing");

    a_req_one_low: assert property (@(posedge pclk) disable iff (!presetn)
        !(s_q.ctrl[epic_pkg::flag_one_bit] && s_q.ctrl[epic_pkg::en_one_bit]) |=> !src_one_req)
        else $error("req one stray");

    a_req_two_low: assert property (@(posedge pclk) disable iff (!presetn)
        !(s_q.ctrl[epic_pkg::flag_two_bit] && s_q.ctrl[epic_pkg::en_two_bit]) |=> !src_two_req)
        else $error("req two stray");

    a_en_one_write: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> s_q.ctrl[epic_pkg::en_one_bit] == $past(pwdata[epic_pkg::en_one_bit]))
        else $error("enable one not written");

    a_en_two_write: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> s_q.ctrl[epic_pkg::en_two_bit] == $past(pwdata[epic_pkg::en_two_bit]))
        else $error("enable two not written");

    a_flag_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_two && !s_q.ctrl[epic_pkg::en_two_bit]) |=> s_q.ctrl[epic_pkg::flag_two_bit])
        else $error("flag gated by enable");

    a_flag_one_free: assert property (@(posedge pclk) disable iff (!presetn)
        (ev_one && !s_q.ctrl[epic_pkg::en_one_bit]) |=> s_q.ctrl[epic_pkg::flag_one_bit])
        else $error("flag one gated by enable");

    a_periph_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        periph_events_a[0] |=> s_q.periph_a[0]) else $error("periph flag lost");

    a_periph_b_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        periph_events_b[7] |=> s_q.periph_b[7]) else $error("periph b flag lost");

    a_periph_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == epic_pkg::periph_a_addr && !pwdata[0] && !periph_events_a[0])
        |=> !s_q.periph_a[0]) else $error("periph flag not cleared");

    // The pin register and the peripheral registers must not disturb each other.
    a_periph_apart: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_wr && periph_events_a == 8'h00) |=> $stable(s_q.periph_a))
        else $error("periph moved by ctrl");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ctrl[5] == 1'b0 && s_q.ctrl[2] == 1'b0) else $error("reserved bit set");

    a_prio_one_write: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> s_q.ctrl[epic_pkg::prio_one_bit] == $past(pwdata[epic_pkg::prio_one_bit]))
        else $error("priority one not written");

    a_prio_one_follow: assert property (@(posedge pclk) disable iff (!presetn)
        src_one_high == $past(s_q.ctrl[epic_pkg::prio_one_bit]))
        else $error("priority one output wrong");

    a_prio_two_follow: assert property (@(posedge pclk) disable iff (!presetn)
        src_two_high == $past(s_q.ctrl[epic_pkg::prio_two_bit]))
        else $error("priority two output wrong");

    a_rise_detect: assert property (@(posedge pclk) disable iff (!presetn)
        epic_rise_one |-> ev_one) else $error("rising edge missed");

    a_fall_detect_one: assert property (@(posedge pclk) disable iff (!presetn)
        epic_fall_one |-> ev_one) else $error("falling edge one missed");

    a_rise_detect_two: assert property (@(posedge pclk) disable iff (!presetn)
        epic_rise_two |-> ev_two) else $error("rising edge two missed");

    a_fall_detect_two: assert property (@(posedge pclk) disable iff (!presetn)
        epic_fall_two |-> ev_two) else $error("falling edge two missed");

    // A pin that holds its level for two cycles must not report an event.
    a_still_one: assert property (@(posedge pclk) disable iff (!presetn)
        epic_still_one |-> !ev_one) else $error("event one without edge");

    a_still_two: assert property (@(posedge pclk) disable iff (!presetn)
        epic_still_two |-> !ev_two) else $error("event two without edge");

    a_edge_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == epic_pkg::edge_addr) |=> s_q.edge_sel == $past(pwdata[1:0]))
        else $error("edge select not written");

    a_edge_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == epic_pkg::edge_addr) |=> $stable(s_q.edge_sel))
        else $error("edge select moved");
endmodule : epic_top
`default_nettype wire

// ### testbench/epic_pin_model.sv
// Model of the two external interrupt pins that feed the block.
// Assumes the bench asks for pin levels; the pins move only on rising pclk.
`timescale 1ns/1ps
`default_nettype none
module epic_pin_model (
    input wire logic pclk,
    input wire logic want_one,
    input wire logic want_two,
    output logic pin_one,
    output logic pin_two
);
    // Pins start low, so reset release sees no stray rising edge.
    initial begin
        pin_one = 1'b0;
        pin_two = 1'b0;
    end
    always @(posedge pclk) begin
        pin_one <= want_one;
        pin_two <= want_two;
    end
endmodule : epic_pin_model
`default_nettype wire

// ### testbench/tb.sv
// Bench for the pin interrupt block: APB reads and writes with expected values.
// Assumes zero or more wait states and the pin model of this folder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    localparam logic [11:0] ca = epic_pkg::ctrl_addr;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, one_r, two_r, one_h, two_h, pin_one, pin_two;
    logic want_one = 1'b0, want_two = 1'b0;
    logic [7:0] ev_a = 8'h00, ev_b = 8'h00;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    epic_pin_model u_epic_pin_model (.pclk(pclk), .want_one(want_one), .want_two(want_two),
        .pin_one(pin_one), .pin_two(pin_two));
    epic_top u_epic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pin_source_one(pin_one), .ext_pin_source_two(pin_two),
        .periph_events_a(ev_a), .periph_events_b(ev_b), .src_one_req(one_r),
        .src_two_req(two_r), .src_one_high(one_h), .src_two_high(two_h));
    task automatic conclude();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // The request is held until pready is seen high; data is taken at that edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    task automatic pins(input logic one, input logic two);
        want_one <= one;
        want_two <= two;
        repeat (4) @(posedge pclk);
    endtask : pins
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(ca, {24'h0, epic_pkg::ctrl_rst});
        `CHK({two_h, one_h}, 2'b11)
        rchk(epic_pkg::edge_addr, 32'h3);
        rchk(epic_pkg::pend_addr, 32'hc);
        apb(1'b1, ca, 32'hff);
        rchk(ca, 32'hdb);
        rchk(epic_pkg::pend_addr, 32'hf);
        apb(1'b1, ca, 32'h0);
        rchk(epic_pkg::pend_addr, 32'h0);
        `CHK({two_h, one_h}, 2'b00)
        pins(1'b1, 1'b0);
        rchk(ca, 32'h1);
        `CHK(one_r, 1'b0)
        pins(1'b0, 1'b0);
        rchk(ca, 32'h1);
        apb(1'b1, ca, 32'h0);
        rchk(ca, 32'h0);
        apb(1'b1, epic_pkg::edge_addr, 32'h0);
        pins(1'b0, 1'b1);
        rchk(ca, 32'h0);
        pins(1'b0, 1'b0);
        rchk(ca, 32'h2);
        apb(1'b1, ca, 32'h12);
        repeat (2) @(posedge pclk);
        `CHK({two_r, one_r}, 2'b10)
        apb(1'b1, ca, 32'h10);
        repeat (2) @(posedge pclk);
        `CHK(two_r, 1'b0)
        ev_a <= 8'h81;
        @(posedge pclk);
        ev_a <= 8'h00;
        rchk(epic_pkg::periph_a_addr, 32'h81);
        rchk(epic_pkg::periph_b_addr, 32'h0);
        rchk(ca, 32'h10);
        apb(1'b1, epic_pkg::periph_a_addr, 32'h01);
        rchk(epic_pkg::periph_a_addr, 32'h01);
        rchk(12'h014, 32'h0);
        `CHK(err, 1'b1)
        conclude();
    end
endmodule : tb
`default_nettype wire
